// file: beac_pkg.sv
/*
  Package for the byte nonvolatile store access controller.
  Holds register indices, control field positions, mode codes and the
  programming times, shared by the device end and the host end.
  Assumes a 50 MHz system clock.
*/
`default_nettype none

package beac_pkg;

  // Register indices on the device's own I/O port.
  localparam logic [1:0] BEAC_IDX_ADDR = 2'h0;
  localparam logic [1:0] BEAC_IDX_DATA = 2'h1;
  localparam logic [1:0] BEAC_IDX_CTRL = 2'h2;

  // Control register field positions.
  localparam int BEAC_CTRL_READ  = 0;
  localparam int BEAC_CTRL_PROG  = 1;
  localparam int BEAC_CTRL_ARM   = 2;
  localparam int BEAC_CTRL_RIE   = 3;
  localparam int BEAC_CTRL_MODE0 = 4;
  localparam int BEAC_CTRL_MODE1 = 5;

  // Programming modes.
  localparam logic [1:0] BEAC_MODE_ERASE_WRITE = 2'h0;
  localparam logic [1:0] BEAC_MODE_ERASE_ONLY  = 2'h1;
  localparam logic [1:0] BEAC_MODE_WRITE_ONLY  = 2'h2;
  localparam logic [1:0] BEAC_MODE_RESERVED    = 2'h3;

  // Store geometry and values.
  localparam int         BEAC_DEPTH      = 128;
  localparam logic [7:0] BEAC_ERASED     = 8'hFF;
  localparam logic [7:0] BEAC_ADDR_MASK  = 8'h7F;
  localparam logic [7:0] BEAC_CTRL_MASK  = 8'h3F;

  // Timing: clock rate, times in microseconds, derived cycle counts.
  localparam int BEAC_CLK_HZ       = 50_000_000;
  localparam int BEAC_T_EW_US      = 3400;
  localparam int BEAC_T_SPLIT_US   = 1800;
  localparam int BEAC_EW_CYCLES    = BEAC_T_EW_US * (BEAC_CLK_HZ / 1_000_000);
  localparam int BEAC_SPLIT_CYCLES =
    BEAC_T_SPLIT_US * (BEAC_CLK_HZ / 1_000_000);
  localparam logic [2:0] BEAC_ARM_CYCLES   = 3'h4;
  localparam logic [2:0] BEAC_PROG_STALL   = 3'h2;
  localparam logic [2:0] BEAC_READ_STALL   = 3'h4;

  // Host command register offsets on APB.
  localparam logic [7:0] BEAC_APB_CMD    = 8'h00;
  localparam logic [7:0] BEAC_APB_WDATA  = 8'h04;
  localparam logic [7:0] BEAC_APB_STATUS = 8'h08;

  // Host command codes.
  localparam logic [1:0] BEAC_CMD_RD  = 2'h1;
  localparam logic [1:0] BEAC_CMD_WR  = 2'h2;

endpackage

`default_nettype wire

// file: beac_if.sv
/*
  Interface joining the processor side (host) and the store controller.
  Assumes one clock shared by both ends; the host issues one register
  access at a time and honours the stall output.
*/
`default_nettype none

interface beac_if;
  logic       io_we;      // Register write strobe, one cycle.
  logic       io_re;      // Register read strobe, one cycle.
  logic [1:0] io_idx;     // Register index.
  logic [7:0] io_wdata;   // Write data.
  logic [7:0] io_rdata;   // Read data, valid the cycle after io_re.
  logic       stall;      // Processor must issue nothing while high.
  logic       gie;        // Global interrupt enable from the host command word.
  logic       irq;        // Level ready interrupt.

  modport dev (
    input  io_we, io_re, io_idx, io_wdata, gie,
    output io_rdata, stall, irq
  );
  modport host (
    output io_we, io_re, io_idx, io_wdata, gie,
    input  io_rdata, stall, irq
  );
endinterface

`default_nettype wire

// file: beac_dev.sv
/*
  Byte nonvolatile store access controller, device end.
  Holds the address, data and control registers, the 128-byte store,
  the arm window, programming timer and processor stall.
  Assumes the host issues no access while stall is high and that the
  host treats io_rdata as valid one cycle after io_re.
*/
// Implementation choices: the placing of the registers and register access over APB.
// Functional notes
// - 128 bytes, linear addresses 0 to 127.
// - Address uses bits 6..0; bit 7 reads zero.
// - Software loads address before any access.
// - Data register feeds writes, receives read bytes.
// - Control bits 7 and 6 read zero.
// - Mode selects erase+write, erase, write, reserved.
// - Mode writes ignored while program strobe set.
// - Reset clears mode unless programming runs.
// - Ready interrupt held while enabled and idle.
// - Arm bit self-clears four cycles after set.
// - Program starts only within armed window.
// - Program strobe stays until time elapses.
// - Program strobe stalls processor two cycles.
// - Read fetches byte, stalls four cycles.
// - No reads or address changes while programming.
// - No new operation until current completes.
// - Write-only needs prior erase by software.
// - Software polls strobe before reading.
// - Programming timed by a calibrated clock; here the timer counts system clock cycles.
// - Programming survives reset to completion.
`default_nettype none

module beac_dev #(
  parameter int EW_CYCLES    = beac_pkg::BEAC_EW_CYCLES,
  parameter int SPLIT_CYCLES = beac_pkg::BEAC_SPLIT_CYCLES
) (
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  beac_if.dev       bus
);
  import beac_pkg::*;

  typedef struct packed {
    logic [6:0]  addr;
    logic [7:0]  data;
    logic [1:0]  mode;
    logic        rie;
    logic        arm;
    logic [2:0]  arm_cnt;
    logic        prog;
    logic [1:0]  prog_mode;
    logic [6:0]  prog_addr;
    logic [7:0]  prog_data;
    logic [21:0] timer;
    logic [2:0]  stall_cnt;
    logic [7:0]  rdata;
    logic        irq;
    logic        stall;
  } beac_dev_state_t;

  // The registers live in two copies of the state struct; s_q merges them.
  beac_dev_state_t s_q;            // Merged view of both register groups.
  beac_dev_state_t s_d;
  beac_dev_state_t r_q;            // Group cleared by reset.
  beac_dev_state_t e_q;            // Engine group that runs through reset.
  logic            boot_q = 1'b0;  // Power-up marker, clear until an edge.
  logic [7:0]      mem_q [BEAC_DEPTH];
  logic            commit;

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic for the registers, arm window and timer.
  always_comb begin
    logic [7:0] ctrl_rd;
    ctrl_rd = 8'h00;
    s_d     = s_q;
    commit  = 1'b0;
    // Control read view: reserved bits stay zero.
    ctrl_rd[BEAC_CTRL_MODE1] = s_q.mode[1];
    ctrl_rd[BEAC_CTRL_MODE0] = s_q.mode[0];
    ctrl_rd[BEAC_CTRL_RIE]   = s_q.rie;
    ctrl_rd[BEAC_CTRL_ARM]   = s_q.arm;
    ctrl_rd[BEAC_CTRL_PROG]  = s_q.prog;
    // Arm window counts down and clears itself.
    if (s_q.arm) begin
      if (s_q.arm_cnt == 3'h1) begin
        s_d.arm = 1'b0;
      end
      s_d.arm_cnt = s_q.arm_cnt - 3'h1;
    end
    // Stall counter.
    if (s_q.stall_cnt != 3'h0) begin
      s_d.stall_cnt = s_q.stall_cnt - 3'h1;
    end
    // Programming timer, run at the system clock as the timing source.
    if (s_q.prog) begin
      if (s_q.timer == 22'h0) begin
        s_d.prog = 1'b0;
        commit   = (s_q.prog_mode != BEAC_MODE_RESERVED);
      end else begin
        s_d.timer = s_q.timer - 22'h1;
      end
    end
    // Register reads.
    if (bus.io_re) begin
      unique case (bus.io_idx)
        BEAC_IDX_ADDR: s_d.rdata = {1'b0, s_q.addr};
        BEAC_IDX_DATA: s_d.rdata = s_q.data;
        BEAC_IDX_CTRL: s_d.rdata = ctrl_rd;
        default:       s_d.rdata = 8'h00;
      endcase
    end
    // Register writes.
    if (bus.io_we) begin
      unique case (bus.io_idx)
        BEAC_IDX_ADDR: begin
          if (!s_q.prog) begin
            s_d.addr = bus.io_wdata[6:0];
          end
        end
        BEAC_IDX_DATA: s_d.data = bus.io_wdata;
        BEAC_IDX_CTRL: begin
          s_d.rie = bus.io_wdata[BEAC_CTRL_RIE];
          if (!s_q.prog) begin
            s_d.mode = bus.io_wdata[BEAC_CTRL_MODE1:BEAC_CTRL_MODE0];
          end
          if (bus.io_wdata[BEAC_CTRL_ARM] && !s_q.arm) begin
            s_d.arm     = 1'b1;
            s_d.arm_cnt = BEAC_ARM_CYCLES;
          end
          if (bus.io_wdata[BEAC_CTRL_PROG] && s_q.arm && !s_q.prog) begin
            s_d.prog      = 1'b1;
            s_d.prog_mode = s_q.mode;
            s_d.prog_addr = s_q.addr;
            s_d.prog_data = s_q.data;
            s_d.timer     = (s_q.mode == BEAC_MODE_ERASE_WRITE) ?
                            22'(EW_CYCLES - 1) : 22'(SPLIT_CYCLES - 1);
            s_d.arm       = 1'b0;
            s_d.stall_cnt = BEAC_PROG_STALL;
          end else if (bus.io_wdata[BEAC_CTRL_READ] && !s_q.prog) begin
            s_d.data      = mem_q[s_q.addr];
            s_d.stall_cnt = BEAC_READ_STALL;
          end
        end
        default: ;
      endcase
    end
    s_d.stall = (s_d.stall_cnt != 3'h0);
    s_d.irq   = s_q.rie && bus.gie && !s_d.prog;
  end

  //////////////////////////////////////////////////////////////////////////
  // Register group cleared by reset: address, data, arm window, stall
  // counter and the registered outputs. Engine fields of this copy are
  // loaded too but never read; the merged view takes them from e_q.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r_q <= '0;
    end else begin
      r_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Programming engine and mode. They ignore reset while programming so that a running
  // operation completes; the timer and the store keep moving while reset
  // is low. The power-up marker forces them to a known idle state; reset while idle returns only the mode to erase plus write.
  always_ff @(posedge clock_i) begin
    boot_q <= 1'b1;
    e_q    <= s_d;
    if (!boot_q) begin
      e_q.prog <= 1'b0;
      e_q.mode <= BEAC_MODE_ERASE_WRITE;
    end else if (!rst_b_i && !s_q.prog) begin
      // Idle during reset: mode returns to erase plus write.
      e_q.mode <= BEAC_MODE_ERASE_WRITE;
    end
  end

  // Merged view of both groups, read by the next-state logic and store.
  always_comb begin
    s_q           = r_q;
    s_q.mode      = e_q.mode;
    s_q.prog      = e_q.prog;
    s_q.prog_mode = e_q.prog_mode;
    s_q.prog_addr = e_q.prog_addr;
    s_q.prog_data = e_q.prog_data;
    s_q.timer     = e_q.timer;
  end

  //////////////////////////////////////////////////////////////////////////
  // Store array: erase sets ones, write ANDs in new zeros.
  for (genvar i = 0; i < BEAC_DEPTH; i++) begin : g_cell
    always_ff @(posedge clock_i) begin
      if (commit && s_q.prog_addr == 7'(i)) begin
        unique case (s_q.prog_mode)
          BEAC_MODE_ERASE_WRITE: mem_q[i] <= s_q.prog_data;
          BEAC_MODE_ERASE_ONLY:  mem_q[i] <= BEAC_ERASED;
          BEAC_MODE_WRITE_ONLY:  mem_q[i] <= mem_q[i] & s_q.prog_data;
          default:               mem_q[i] <= mem_q[i];
        endcase
      end
    end
  end

  assign bus.io_rdata = r_q.rdata;
  assign bus.stall    = r_q.stall;
  assign bus.irq      = r_q.irq;

endmodule

`default_nettype wire

// file: beac_host.sv
/*
  Host end: takes byte read and program orders over APB and performs the
  documented register sequences toward the store controller.
  Assumes the device end on the other side of beac_if and one clock.
*/
`default_nettype none

module beac_host (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  beac_if.host             bus
);
  import beac_pkg::*;

  typedef enum logic [3:0] {
    BH_IDLE, BH_POLL, BH_POLL_RD, BH_ADDR, BH_DATA, BH_ARM, BH_PROG,
    BH_READ, BH_GET, BH_GET_RD
  } beac_host_st_t;

  typedef struct packed {
    beac_host_st_t st;
    logic [1:0]    cmd;
    logic [1:0]    mode;
    logic [6:0]    addr;
    logic [7:0]    wdata;
    logic [7:0]    result;
    logic          busy;
    logic          gie;
    logic [31:0]   prdata;
    logic          pready;
    logic          we;
    logic          re;
    logic [1:0]    idx;
    logic [7:0]    iwd;
  } beac_host_state_t;

  beac_host_state_t h_q;
  beac_host_state_t h_d;

  //////////////////////////////////////////////////////////////////////////
  // APB slave plus the register sequence engine.
  always_comb begin
    logic acc;
    acc          = psel_i && penable_i && !h_q.pready;
    h_d          = h_q;
    h_d.pready   = acc;
    h_d.we       = 1'b0;
    h_d.re       = 1'b0;
    if (acc) begin
      h_d.prdata = 32'h0;
      if (pwrite_i && paddr_i == BEAC_APB_CMD && !h_q.busy) begin
        h_d.cmd  = pwdata_i[1:0];
        h_d.mode = pwdata_i[9:8];
        h_d.addr = pwdata_i[22:16];
        h_d.gie  = pwdata_i[31];
        h_d.busy = (pwdata_i[1:0] != 2'h0);
      end else if (pwrite_i && paddr_i == BEAC_APB_WDATA) begin
        h_d.wdata = pwdata_i[7:0];
      end else if (!pwrite_i && paddr_i == BEAC_APB_STATUS) begin
        // Status also reports the ready request in bit 9.
        h_d.prdata = {22'h0, bus.irq, h_q.busy, h_q.result};
      end
    end
    // Issue nothing to the device while it stalls the processor.
    if (!bus.stall && !h_q.we && !h_q.re) begin
      unique case (h_q.st)
        BH_IDLE: if (h_q.busy) h_d.st = BH_POLL;
        BH_POLL: begin
          h_d.re  = 1'b1;
          h_d.idx = BEAC_IDX_CTRL;
          h_d.st  = BH_POLL_RD;
        end
        BH_POLL_RD: begin
          if (bus.io_rdata[BEAC_CTRL_PROG]) h_d.st = BH_POLL;
          else h_d.st = BH_ADDR;
        end
        BH_ADDR: begin
          h_d.we  = 1'b1;
          h_d.idx = BEAC_IDX_ADDR;
          h_d.iwd = {1'b0, h_q.addr};
          h_d.st  = (h_q.cmd == BEAC_CMD_RD) ? BH_READ : BH_DATA;
        end
        BH_DATA: begin
          h_d.we  = 1'b1;
          h_d.idx = BEAC_IDX_DATA;
          h_d.iwd = h_q.wdata;
          h_d.st  = BH_ARM;
        end
        BH_ARM: begin
          h_d.we  = 1'b1;
          h_d.idx = BEAC_IDX_CTRL;
          h_d.iwd = {2'h0, h_q.mode, 4'hC};  // Arm, ready request on.
          h_d.st  = BH_PROG;
        end
        BH_PROG: begin
          h_d.we   = 1'b1;
          h_d.idx  = BEAC_IDX_CTRL;
          h_d.iwd  = {2'h0, h_q.mode, 4'hA};
          h_d.busy = 1'b0;
          h_d.st   = BH_IDLE;
        end
        BH_READ: begin
          h_d.we  = 1'b1;
          h_d.idx = BEAC_IDX_CTRL;
          h_d.iwd = 8'h09;
          h_d.st  = BH_GET;
        end
        BH_GET: begin
          h_d.re  = 1'b1;
          h_d.idx = BEAC_IDX_DATA;
          h_d.st  = BH_GET_RD;
        end
        BH_GET_RD: begin
          h_d.result = bus.io_rdata;
          h_d.busy   = 1'b0;
          h_d.st     = BH_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      h_q <= '{st: BH_IDLE, default: '0};
    end else begin
      h_q <= h_d;
    end
  end

  assign prdata_o     = h_q.prdata;
  assign pready_o     = h_q.pready;
  assign pslverr_o    = 1'b0;
  assign bus.io_we    = h_q.we;
  assign bus.io_re    = h_q.re;
  assign bus.io_idx   = h_q.idx;
  assign bus.io_wdata = h_q.iwd;
  assign bus.gie      = h_q.gie;

endmodule

`default_nettype wire

// file: beac_assertions.sv
/*
  Checker for the link between the host end and the store controller.
  Assumes it is instantiated beside the interface with one shared clock
  and that the host polls the program strobe before issuing reads.
*/
`default_nettype none

module beac_assertions
  import beac_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       rst_b_i,
  input wire logic       io_we,
  input wire logic       io_re,
  input wire logic [1:0] io_idx,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic       stall,
  input wire logic       gie,
  input wire logic       irq
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  ////////////////////////////////////////////////////////////////////////
  // Decoded control writes, so each property reads as its cause.
  logic ctrl_wr;
  logic rd_go;
  logic pg_go;
  assign ctrl_wr = io_we && (io_idx == BEAC_IDX_CTRL);
  assign rd_go   = ctrl_wr && io_wdata[BEAC_CTRL_READ]
                   && !io_wdata[BEAC_CTRL_PROG];
  assign pg_go   = ctrl_wr && io_wdata[BEAC_CTRL_PROG];

  ////////////////////////////////////////////////////////////////////////
  // Stall lengths, strobe discipline, reserved bits and the ready request.
  a_read_stall_four: assert property (
    rd_go |=> stall [*4] ##1 !stall)
    else $error("read strobe did not stall four cycles");
  a_prog_stall_two: assert property (
    pg_go |=> stall [*2] ##1 !stall)
    else $error("program strobe did not stall two cycles");
  a_stall_blocks_access: assert property (
    stall |-> !io_we && !io_re)
    else $error("access issued while stalled");
  a_strobe_gap_kept: assert property (
    (io_we || io_re) |=> !(io_we || io_re))
    else $error("strobes issued back to back");
  a_ctrl_top_zero: assert property (
    io_re && (io_idx == BEAC_IDX_CTRL) |=> io_rdata[7:6] == 2'h0)
    else $error("control reserved bits read nonzero");
  a_addr_top_zero: assert property (
    io_re && (io_idx == BEAC_IDX_ADDR) |=> io_rdata[7] == 1'b0)
    else $error("address top bit read nonzero");
  a_irq_needs_gie: assert property (
    !gie |=> !irq)
    else $error("ready request with global enable clear");
  a_irq_low_busy: assert property (
    pg_go |-> ##3 !irq [*8])
    else $error("ready request during programming");
  a_index_legal: assert property (
    (io_we || io_re) |-> io_idx != 2'h3)
    else $error("access to unused register index");

  // Main scenarios seen on the link.
  c_read: cover property (rd_go);
  c_prog: cover property (pg_go);
  c_irq: cover property ($rose(irq));
endmodule

`default_nettype wire

// file: tb_top.sv
/*
  Testbench: drives the host end over APB, host and device joined by the
  interface, and checks stored bytes, timing and refusals.
  Assumes shortened programming counts and one 50 MHz clock.
*/
`default_nettype none

`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
  errors++; $display("unexpected %s exp %h got %h", nm, ex, got); end end

module tb_top;
  import beac_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int EW = 200;
  localparam int SP = 60;

  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] s;
  logic        gie_sel = 1'b1;
  int          errors  = 0;
  int          checks  = 0;

  beac_if beac_if_inst ();
  beac_dev #(.EW_CYCLES(EW), .SPLIT_CYCLES(SP)) beac_dev_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .bus(beac_if_inst));
  beac_host beac_host_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .bus(beac_if_inst));
  beac_assertions beac_assertions_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .io_we(beac_if_inst.io_we),
    .io_re(beac_if_inst.io_re), .io_idx(beac_if_inst.io_idx),
    .io_wdata(beac_if_inst.io_wdata), .io_rdata(beac_if_inst.io_rdata),
    .stall(beac_if_inst.stall), .gie(beac_if_inst.gie),
    .irq(beac_if_inst.irq));

  // Clock of 20 ns period.
  always #10 clock_i = ~clock_i;

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run.
  task automatic summarize();
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clock_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Builds and sends a command word.
  task automatic cmd(input logic [1:0] c, input logic [1:0] m,
                     input logic [6:0] a);
    logic [31:0] w;
    logic [31:0] r;
    w = 32'h0;
    w[1:0] = c;
    w[9:8] = m;
    w[22:16] = a;
    w[31] = gie_sel;
    apb(1'b1, BEAC_APB_CMD, w, r);
  endtask

  // Polls status until the busy flag clears, bounded.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin apb(1'b0, BEAC_APB_STATUS, 32'h0, s); n++; end
    while (s[8] !== 1'b0 && n < 300);
    `CHK("busy", 1'b0, s[8])
  endtask

  // Programs one byte in the given mode.
  task automatic prog(input logic [6:0] a, input logic [1:0] m,
                      input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, BEAC_APB_WDATA, {24'h0, d}, r);
    cmd(BEAC_CMD_WR, m, a);
  endtask

  // Reads one byte back and compares it.
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] ex);
    cmd(BEAC_CMD_RD, 2'h0, a);
    wait_idle();
    `CHK("byte", ex, s[7:0])
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog against a hang.
  initial begin
    repeat (40000) @(posedge clock_i);
    errors++;
    summarize();
  end

  // Main sequence.
  initial begin
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    apb(1'b0, BEAC_APB_STATUS, 32'h0, s);
    `CHK("busy after reset", 1'b0, s[8])
    prog(7'h00, BEAC_MODE_ERASE_WRITE, 8'hA5);
    repeat (120) @(posedge clock_i);
    // A read order must wait behind the long program still running.
    cmd(BEAC_CMD_RD, 2'h0, 7'h00);
    apb(1'b0, BEAC_APB_STATUS, 32'h0, s);
    `CHK("busy long", 1'b1, s[8])
    `CHK("irq busy", 1'b0, s[9])
    wait_idle();
    `CHK("irq ready", 1'b1, s[9])
    rd_chk(7'h00, 8'hA5);
    prog(7'h7F, BEAC_MODE_ERASE_ONLY, 8'h00);
    repeat (120) @(posedge clock_i);
    // The short program is over, so a read order finishes at once.
    cmd(BEAC_CMD_RD, 2'h0, 7'h7F);
    repeat (20) @(posedge clock_i);
    apb(1'b0, BEAC_APB_STATUS, 32'h0, s);
    `CHK("busy short", 1'b0, s[8])
    rd_chk(7'h7F, BEAC_ERASED);
    gie_sel = 1'b0;
    prog(7'h7F, BEAC_MODE_WRITE_ONLY, 8'h3C);
    wait_idle();
    rd_chk(7'h7F, 8'h3C);
    `CHK("irq masked", 1'b0, s[9])
    prog(7'h7F, BEAC_MODE_WRITE_ONLY, 8'h0F);
    wait_idle();
    rd_chk(7'h7F, 8'h0C);
    prog(7'h7F, BEAC_MODE_RESERVED, 8'h00);
    wait_idle();
    rd_chk(7'h7F, 8'h0C);
    gie_sel = 1'b1;
    // A read order sent while the host is still busy with a program order is refused.
    prog(7'h01, BEAC_MODE_ERASE_WRITE, 8'h11);
    cmd(BEAC_CMD_RD, 2'h0, 7'h00);
    wait_idle();
    `CHK("last byte", 8'h0C, s[7:0])
    rd_chk(7'h01, 8'h11);
    // Reset in mid-programming; the operation still completes.
    prog(7'h03, BEAC_MODE_ERASE_WRITE, 8'h5A);
    repeat (30) @(posedge clock_i);
    rst_b_i <= 1'b0;
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (300) @(posedge clock_i);
    rd_chk(7'h03, 8'h5A);
    rd_chk(7'h00, 8'hA5);
    apb(1'b0, 8'h0C, 32'h0, s);
    `CHK("unmapped", 32'h0, s)
    summarize();
  end
endmodule

`default_nettype wire
